// ---- include/adcc_consts.vh ----
// register offsets, field positions, reset values and timing for the converter control block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
`define ADCC_OFF_RESULT_LOW 12'h000
`define ADCC_OFF_RESULT_HIGH 12'h004
`define ADCC_OFF_CTRL_ZERO 12'h008
`define ADCC_OFF_CTRL_ONE 12'h00c
`define ADCC_OFF_PIN_ENABLE 12'h010
`define ADCC_OFF_IRQ_STATUS 12'h014
`define ADCC_OFF_IRQ_MASK 12'h018
`define ADCC_OFF_SYS_CTRL 12'h01c
// converter_control_zero fields
`define ADCC_C0_START 7
`define ADCC_C0_BUSY 6
`define ADCC_C0_PDOWN 5
`define ADCC_C0_ALIGN 4
`define ADCC_C0_MASK 8'hb7
`define ADCC_C0_RESET 8'h60
// converter_control_one fields
`define ADCC_C1_BG_SEL 7
`define ADCC_C1_BG_EN 6
`define ADCC_C1_MASK 8'hcf
`define ADCC_C1_RESET 8'h00
`define ADCC_PIN_RESET 8'hff
// sys ctrl: bit 0 low_voltage_reset enable
`define ADCC_SYS_LVR 0
`define ADCC_SYS_RESET 8'h01
// successive approximation: timeout after 16 conversion clock ticks
`define ADCC_CONV_TICKS 5'h10
`endif

// ---- core/adcc_clkdiv.v ----
// conversion clock tick generator: one-cycle tick every 2^sel system clocks
// assumes sel 3'h7 undefined; it is treated as divide by 64
module adcc_clkdiv (
  // clock and reset
  input wire clock,
  input wire rst,
  // control
  input wire run,
  input wire [2:0] sel,
  // tick
  output reg tick
);
  reg [5:0] count;
  wire [5:0] limit;
  assign limit = (sel == 3'h7) ? 6'h3f : ((6'h01 << sel) - 6'h01);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= 6'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 6'h00;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 6'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick <= 1'b0;
    end
  end
endmodule // adcc_clkdiv

// ---- core/adcc_result_fmt.v ----
// formats the 12-bit result into high/low bytes for the chosen alignment
// purely combinational, fed from the stored result
module adcc_result_fmt (
  // input
  input wire [11:0] value,
  input wire right_align,
  // formatted bytes
  output wire [7:0] high_byte,
  output wire [7:0] low_byte
);
  assign high_byte = right_align ? {4'h0, value[11:8]} : value[11:4];
  assign low_byte = right_align ? value[7:0] : {value[3:0], 4'h0};
endmodule // adcc_result_fmt

// ---- core/adcc_top.v ----
// converter control and result logic behind an apb slave
// assumes the analog core answers with its sample on conv_data when conv_done pulses
`include "adcc_consts.vh"
module adcc_top (
  // clock and reset
  input wire clock,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // analog core
  input wire [11:0] conv_data,
  input wire conv_done,
  output reg [7:0] input_connect,
  output reg bandgap_route,
  output reg bandgap_power,
  output reg converter_power,
  output reg converter_reset,
  output reg sample_tick,
  // pin muxing
  output reg [7:0] pin_analog,
  output reg [7:0] pin_digital_enable,
  output reg [7:0] pin_pullup_allow,
  // interrupt
  output reg irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_CONV = 2'h2;

  reg [7:0] ctrl_zero;
  reg [7:0] ctrl_one;
  reg [7:0] analog_pin_enables;
  reg [7:0] sys_ctrl;
  reg [11:0] result;
  reg conversion_busy_flag;
  reg [1:0] state;
  reg [4:0] ticks;
  reg [0:0] irq_status;
  reg [0:0] irq_mask;
  reg conv_done_q1;
  reg conv_done_q2;
  reg [11:0] conv_data_q1;
  reg [11:0] conv_data_q2;
  reg [31:0] next_rdata;
  reg next_slverr;
  reg end_evt;
  wire [7:0] result_high_byte;
  wire [7:0] result_low_byte;
  wire div_tick;
  wire wr_en;
  wire acc;
  wire start_bit;
  wire converter_power_down;
  wire result_align_select;
  wire [2:0] channel_select_field;
  wire bandgap_input_select;
  wire bandgap_enable;
  wire [2:0] conversion_clock_divider;
  wire low_voltage_reset;


  // decode of one-hot channel, used only by the input routing
  // bandgap select forces zero so no external input shares the converter
  function [7:0] chan_onehot;
    input [2:0] ch;
    input off;
    begin
      chan_onehot = off ? 8'h00 : (8'h01 << ch);
    end
  endfunction


  // access phase; writes land only at the edge where pready is seen high
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && pready;
  assign start_bit = ctrl_zero[`ADCC_C0_START];
  assign converter_power_down = ctrl_zero[`ADCC_C0_PDOWN];
  assign result_align_select = ctrl_zero[`ADCC_C0_ALIGN];
  assign channel_select_field = ctrl_zero[2:0];
  assign bandgap_input_select = ctrl_one[`ADCC_C1_BG_SEL];
  assign bandgap_enable = ctrl_one[`ADCC_C1_BG_EN];
  assign conversion_clock_divider = ctrl_one[2:0];
  assign low_voltage_reset = sys_ctrl[`ADCC_SYS_LVR];


  // divider only runs while converting, so its phase restarts each conversion
  adcc_clkdiv u_div (
    .clock(clock),
    .rst(rst),
    .run(state == ST_CONV),
    .sel(conversion_clock_divider),
    .tick(div_tick)
  );


  // formatting happens at read time, so the align bit can change after the result
  adcc_result_fmt u_fmt (
    .value(result),
    .right_align(result_align_select),
    .high_byte(result_high_byte),
    .low_byte(result_low_byte)
  );


  // conv_done is from the analog side; synchronise before use
  // data word is taken when done is seen or at the tick limit; on done it has been stable for two edges
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_done_q1 <= 1'b0;
      conv_done_q2 <= 1'b0;
      conv_data_q1 <= 12'h000;
      conv_data_q2 <= 12'h000;
    end else begin
      conv_done_q1 <= conv_done;
      conv_done_q2 <= conv_done_q1;
      conv_data_q1 <= conv_data;
      conv_data_q2 <= conv_data_q1;
    end
  end


  // read mux
  // unmapped addresses answer with an error and zero data
  always @* begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    case (paddr)
      `ADCC_OFF_RESULT_LOW: next_rdata = {24'h000000, result_low_byte};
      `ADCC_OFF_RESULT_HIGH: next_rdata = {24'h000000, result_high_byte};
      `ADCC_OFF_CTRL_ZERO: next_rdata = {24'h000000, ctrl_zero[7], conversion_busy_flag, ctrl_zero[5:0]};
      `ADCC_OFF_CTRL_ONE: next_rdata = {24'h000000, ctrl_one};
      `ADCC_OFF_PIN_ENABLE: next_rdata = {24'h000000, analog_pin_enables};
      `ADCC_OFF_IRQ_STATUS: next_rdata = {31'h00000000, irq_status};
      `ADCC_OFF_IRQ_MASK: next_rdata = {31'h00000000, irq_mask};
      `ADCC_OFF_SYS_CTRL: next_rdata = {24'h000000, sys_ctrl};
      default: next_slverr = 1'b1;
    endcase
  end


  // apb: one wait state, answer in the second access cycle
  // registering the answer keeps the read mux off the bus timing path
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_slverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end


  // software registers; result registers take no write
  // reserved bits are masked on write so they read back zero, except ctrl_one bit 3, which drives nothing yet keeps the value written
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_zero <= `ADCC_C0_RESET;
      ctrl_one <= `ADCC_C1_RESET;
      analog_pin_enables <= `ADCC_PIN_RESET;
      sys_ctrl <= `ADCC_SYS_RESET;
      irq_mask <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `ADCC_OFF_CTRL_ZERO: ctrl_zero <= pwdata[7:0] & `ADCC_C0_MASK;
        `ADCC_OFF_CTRL_ONE: ctrl_one <= pwdata[7:0] & `ADCC_C1_MASK;
        `ADCC_OFF_PIN_ENABLE: analog_pin_enables <= pwdata[7:0];
        `ADCC_OFF_IRQ_MASK: irq_mask <= pwdata[0];
        `ADCC_OFF_SYS_CTRL: sys_ctrl <= {7'h00, pwdata[0]};
        default: ctrl_zero <= ctrl_zero;
      endcase
    end
  end


  // start sequencing: rising edge arms, falling edge launches
  // busy stays one while armed, so software sees the converter held in reset
  // if conv_done never arrives the tick count ends the conversion instead of hanging
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      ticks <= 5'h00;
      conversion_busy_flag <= 1'b1;
      result <= 12'h000;
      end_evt <= 1'b0;
    end else begin
      end_evt <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_bit) begin
            state <= ST_ARMED;
            conversion_busy_flag <= 1'b1;
          end
        end
        ST_ARMED: begin
          conversion_busy_flag <= 1'b1;
          if (!start_bit) begin
            state <= ST_CONV;
            ticks <= 5'h00;
          end
        end
        ST_CONV: begin
          if (start_bit) begin
            // a new rising start aborts and resets the converter
            state <= ST_ARMED;
          end else if (converter_power_down) begin
            state <= ST_IDLE;
          end else if (conv_done_q2 || (div_tick && ticks == `ADCC_CONV_TICKS - 5'h01)) begin
            result <= conv_data_q2;
            conversion_busy_flag <= 1'b0;
            end_evt <= 1'b1;
            state <= ST_IDLE;
          end else if (div_tick) begin
            ticks <= ticks + 5'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end


  // sticky status, write one clears; a new event wins over the clear
  // irq follows status one edge later, which keeps the output straight from a flop
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (end_evt)
        irq_status <= 1'b1;
      else if (wr_en && paddr == `ADCC_OFF_IRQ_STATUS && pwdata[0])
        irq_status <= 1'b0;
      irq <= |(irq_status & irq_mask);
    end
  end


  // analog routing and pin function outputs
  // every output is registered, so routing changes one edge after the register write
  // bandgap stays powered for the voltage reset even when the converter ignores it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      input_connect <= 8'h00;
      bandgap_route <= 1'b0;
      bandgap_power <= 1'b0;
      converter_power <= 1'b0;
      converter_reset <= 1'b1;
      sample_tick <= 1'b0;
      pin_analog <= 8'h00;
      pin_digital_enable <= 8'hff;
      pin_pullup_allow <= 8'hff;
    end else begin
      input_connect <= chan_onehot(channel_select_field, bandgap_input_select);
      bandgap_route <= bandgap_input_select;
      bandgap_power <= (bandgap_enable && bandgap_input_select) || low_voltage_reset;
      converter_power <= !converter_power_down;
      converter_reset <= (state != ST_CONV);
      sample_tick <= div_tick;
      pin_analog <= analog_pin_enables;
      pin_digital_enable <= ~analog_pin_enables;
      pin_pullup_allow <= ~analog_pin_enables;
    end
  end
endmodule // adcc_top

// ---- testbench/adcc_top_sva.sv ----
// port assertions for the converter control block
// assumes adcc_top on one clock with async reset
module adcc_top_sva (
  // clock and reset
  input logic clock,
  input logic rst,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic [31:0] prdata,
  // converter
  input logic [7:0] input_connect,
  input logic bandgap_route,
  input logic converter_power,
  input logic converter_reset,
  // pins and interrupt
  input logic [7:0] pin_analog,
  input logic [7:0] pin_digital_enable,
  input logic [7:0] pin_pullup_allow,
  input logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // one wait state keeps the register read path registered
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready not a pulse");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  src_onehot_a: assert property ($onehot0(input_connect))
    else $error("several inputs connected");
  bg_isolate_a: assert property (bandgap_route |-> input_connect == 8'h00)
    else $error("input connected with bandgap");
  pin_digital_a: assert property (pin_digital_enable == ~pin_analog)
    else $error("digital function on analog pin");
  pin_pullup_a: assert property ((pin_pullup_allow & pin_analog) == 8'h00)
    else $error("pull-high on analog pin");
  power_abort_a: assert property ($fell(converter_power) |-> ##[0:3] converter_reset)
    else $error("converter runs while powered down");
  irq_idle_a: assert property ($rose(irq) |-> converter_reset)
    else $error("irq before conversion end");
  start_seq_a: assert property ($fell(converter_reset) |-> $past(pready && pwrite, 3))
    else $error("conversion without start write");
endmodule // adcc_top_sva

bind adcc_top adcc_top_sva i_adcc_top_sva (.clock, .rst, .psel, .penable, .pwrite, .pready, .pslverr,
  .prdata, .input_connect, .bandgap_route, .converter_power, .converter_reset, .pin_analog,
  .pin_digital_enable, .pin_pullup_allow, .irq);

// ---- testbench/tb_top.sv ----
// self-checking bench for the converter control block
// assumes adcc_top answers apb after one wait state
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, conv_done = 0, last_err;
  logic [11:0] paddr = 0, conv_data = 12'habc;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, bandgap_route, bandgap_power, converter_power, converter_reset, irq, sample_tick;
  logic [7:0] input_connect, pin_analog, pin_digital_enable, pin_pullup_allow;
  int err_count = 0, checks = 0, cyc = 0, ticks_seen = 0;
  always #20 clock = ~clock;
  adcc_top i_adcc_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .conv_data, .conv_done, .input_connect, .bandgap_route, .bandgap_power,
    .converter_power, .converter_reset, .sample_tick, .pin_analog, .pin_digital_enable,
    .pin_pullup_allow, .irq);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // the leading edge keeps psel from being driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task settle;
    repeat (3) @(posedge clock);
  endtask
  task conv;
    wr(12'h008, 32'h80);
    rd(12'h008, 32'hc0);
    check(converter_reset, 1'b1);
    wr(12'h008, 32'h00);
    conv_done <= 1'b1;
    do apb(1'b0, 12'h008, 32'h0); while (q[6] !== 1'b0);
    conv_done <= 1'b0;
    check(q, 32'h0);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (sample_tick === 1'b1) ticks_seen++;
    if (cyc == 20000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(12'h008, 32'h60);
    rd(12'h00c, 32'h0);
    rd(12'h010, 32'hff);
    rd(12'h01c, 32'h1);
    check(converter_power, 1'b0);
    $display("reset values done");
    wr(12'h008, 32'h3f);
    rd(12'h008, 32'h77);
    wr(12'h00c, 32'h4f);
    settle;
    wr(12'h00c, 32'hff);
    rd(12'h00c, 32'hcf);
    settle;
    check({bandgap_route, bandgap_power, input_connect}, 32'h300);
    wr(12'h01c, 32'h0);
    wr(12'h00c, 32'h40);
    settle;
    check(bandgap_power, 1'b0);
    wr(12'h00c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(12'h008, i);
      settle;
      check(input_connect, 8'h01 << i);
    end
    check(converter_power, 1'b1);
    wr(12'h010, 32'h5a);
    settle;
    check({pin_analog, pin_digital_enable, pin_pullup_allow}, 32'h5aa5a5);
    $display("routing done");
    wr(12'h018, 32'h1);
    conv;
    settle;
    check(irq, 1'b1);
    rd(12'h004, 32'hab);
    rd(12'h000, 32'hc0);
    wr(12'h008, 32'h10);
    rd(12'h004, 32'h0a);
    rd(12'h000, 32'hbc);
    wr(12'h000, 32'hff);
    wr(12'h004, 32'hff);
    rd(12'h000, 32'hbc);
    rd(12'h014, 32'h1);
    wr(12'h014, 32'h1);
    settle;
    check(irq, 1'b0);
    wr(12'h018, 32'h0);
    conv;
    settle;
    check(irq, 1'b0);
    wr(12'h018, 32'h1);
    settle;
    check(irq, 1'b1);
    wr(12'h014, 32'h1);
    settle;
    check(irq, 1'b0);
    $display("conversion done");
    wr(12'h008, 32'h20);
    settle;
    check({converter_power, converter_reset}, 32'h1);
    rd(12'h020, 32'h0);
    check(last_err, 1'b1);
    check(ticks_seen > 0, 1'b1);
    $display("power and errors done");
    summarize;
  end
endmodule // tb_top
